// *** hw/afe_ctrl_defs.svh ***
`ifndef AFE_CTRL_DEFS_SVH
`define AFE_CTRL_DEFS_SVH
// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define ADDR_SETUP1 6'h01
`define ADDR_SETUP2 6'h02
`define ADDR_SETUP3 6'h03
`define ADDR_SOFT_RESET 6'h04
`define ADDR_ACYC_RESET 6'h05
`define ADDR_SETUP4 6'h06
`define ADDR_REVISION 6'h07
`define ADDR_SETUP5 6'h08
`define ADDR_SETUP6 6'h09
`define ADDR_RESV_A 6'h0A
`define ADDR_RESV_B 6'h0B
// ------------------------------------------------------------
// reset values and writable bit masks
// ------------------------------------------------------------
`define DEF_SETUP1 8'h03
`define DEF_SETUP2 8'h20
`define DEF_SETUP3 8'h1F
`define DEF_ZERO 8'h00
`define MASK_SETUP1 8'h7F
`define MASK_SETUP2 8'hEF
`define MASK_SETUP5 8'h1F
`define MASK_SETUP6 8'h0F
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ADDR_RD_BIT 4
`define BIT_EN 0
`define BIT_SINGLE_CHANNEL 2
`define BIT_SELECTIVE_PD 3
`define CHAN_LSB 6
`define BIT_LINE 0
`define BIT_ACYC 1
`define BIT_FME 2
`define INTM_LSB 4
`define FM_LSB 6
`define BIT_DET 0
`define VDEL_LSB 1
`define BIT_POL 4
`define SELDIS_LSB 0
// ------------------------------------------------------------
// frame sizes and colour codes
// ------------------------------------------------------------
`define FRAME_BITS 14
`define RD_BITS 4'h8
`define COL_RED 2'h0
`define COL_GREEN 2'h1
`define COL_BLUE 2'h2
`endif

// *** hw/afe_ctrl_pkg.sv ***
`default_nettype none
package afe_ctrl_pkg;
  typedef struct packed {
    logic ser_clk;
    logic ser_in;
    logic ser_latch;
    logic strobe;
    logic cycle;
    logic oe_n;
  } pins_type;

  typedef struct packed {
    logic [3:0] block_off;
    logic green_off;
    logic blue_off;
    logic single_channel;
  } power_type;

  typedef struct packed {
    logic [1:0] in_sel;
    logic [1:0] og_sel;
  } mux_type;

  typedef struct packed {
    pins_type prev;
    logic [13:0] shift_in;
    logic [7:0] rd_shift;
    logic [3:0] rd_cnt;
    logic rd_busy;
    logic ser_out;
    logic [7:0] setup1;
    logic [7:0] setup2;
    logic [7:0] setup3;
    logic [7:0] setup4;
    logic [7:0] setup5;
    logic [7:0] setup6;
    logic [1:0] acyc;
    logic sample;
    power_type power;
    mux_type mux;
    logic pix7;
  } core_state_type;
endpackage
`default_nettype wire

// *** hw/pin_sync.sv ***
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  // ------------------------------------------------------------
  // two flops, first one feeds only the second
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_sync = st_r.s2;
endmodule // pin_sync
`default_nettype wire

// *** hw/strobe_delay_line.sv ***
`default_nettype none
module strobe_delay_line (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_pulse,
  input wire logic [2:0] i_delay,
  output logic o_pulse
);
  typedef struct packed {
    logic [6:0] taps;
  } dly_state_type;

  dly_state_type st_r;
  dly_state_type st_nxt;
  logic [7:0] chain;

  // ------------------------------------------------------------
  // shift chain, tap n is the pulse n clocks late
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt.taps = {st_r.taps[5:0], i_pulse};
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign chain = {st_r.taps, i_pulse};
  assign o_pulse = chain[i_delay];
endmodule // strobe_delay_line
`default_nettype wire

// *** hw/afe_ctrl.sv ***
// What this block does
// - write frame: six address bits then eight data bits, msb first, on serial rise
// - any write to address 000100 resets every register to default
// - read-back sends register with a4 cleared, msb first, on serial falls
// - next input frame shifts in while read-back word still shifts out
// - sample taken on third master rise after strobe goes low (two-flop sync, then register)
// - detect mode: chosen strobe edge makes one internal sample pulse
// - internal pulse delayed by three-bit delay field in master clocks
// - detect mode uses internal pulse, sampling on next master rise
// - without selective power-down, global enable powers all down or up
// - selective power-down ignores enable, disables blocks per disable field
// - registers retained and serial interface live in every power-down state
// - colour line mode powers down green and blue, forces red single_channel
// - auto-cycle pulse steps red, green, blue, red on third master rise after pin rises (two-flop sync)
// - write to auto-cycle reset returns the auto-cycle colour to red
// - no force and no auto-cycle: all muxes follow colour select
// - force without auto-cycle: input forced, offset and gain follow colour
// - force with auto-cycle: input forced, offset and gain auto-cycle
`include "afe_ctrl_defs.svh"
`default_nettype none
module afe_ctrl #(
  parameter logic [7:0] REVISION_ID = 8'h5A // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ser_clk,
  input wire logic i_ser_in,
  input wire logic i_ser_latch,
  input wire logic i_out_enable_n,
  input wire logic i_sample_strobe,
  input wire logic i_cycle_pulse_pin,
  input wire logic i_pix_bit7,
  output logic o_pix_out_bit7,
  output logic o_pix_out_bit7_oe,
  output logic o_sample_take,
  output afe_ctrl_pkg::power_type o_power,
  output afe_ctrl_pkg::mux_type o_mux
);
  import afe_ctrl_pkg::*;

  core_state_type st_r;
  core_state_type st_nxt;
  pins_type pin_raw;
  pins_type pin_s;
  logic ser_rise;
  logic ser_fall;
  logic latch_rise;
  logic strobe_rise;
  logic strobe_fall;
  logic cyc_rise;
  logic det_en;
  logic det_edge;
  logic dly_pulse;
  logic [5:0] fr_addr;
  logic [7:0] fr_data;
  logic wr_frame;
  logic rd_frame;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  assign pin_raw.ser_clk = i_ser_clk;
  assign pin_raw.ser_in = i_ser_in;
  assign pin_raw.ser_latch = i_ser_latch;
  assign pin_raw.strobe = i_sample_strobe;
  assign pin_raw.cycle = i_cycle_pulse_pin;
  assign pin_raw.oe_n = i_out_enable_n;

  pin_sync #(
    .W($bits(pins_type))
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async(pin_raw),
    .o_sync(pin_s)
  );

  // ------------------------------------------------------------
  // edge detection on synchronised pins
  // ------------------------------------------------------------
  assign ser_rise = pin_s.ser_clk & ~st_r.prev.ser_clk;
  assign ser_fall = ~pin_s.ser_clk & st_r.prev.ser_clk;
  assign latch_rise = pin_s.ser_latch & ~st_r.prev.ser_latch;
  assign strobe_rise = pin_s.strobe & ~st_r.prev.strobe;
  assign strobe_fall = ~pin_s.strobe & st_r.prev.strobe;
  assign cyc_rise = pin_s.cycle & ~st_r.prev.cycle;

  // ------------------------------------------------------------
  // frame decode
  // ------------------------------------------------------------
  assign fr_addr = st_r.shift_in[13:8];
  assign fr_data = st_r.shift_in[7:0];
  assign rd_frame = latch_rise & fr_addr[`ADDR_RD_BIT];
  assign wr_frame = latch_rise & ~fr_addr[`ADDR_RD_BIT];

  // ------------------------------------------------------------
  // strobe detect and delay
  // ------------------------------------------------------------
  assign det_en = st_r.setup5[`BIT_DET];
  assign det_edge = det_en &
    (st_r.setup5[`BIT_POL] ? strobe_rise : strobe_fall);

  strobe_delay_line u_strobe_delay_line (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_pulse(det_edge),
    .i_delay(st_r.setup5[`VDEL_LSB +: 3]),
    .o_pulse(dly_pulse)
  );

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  function automatic logic [7:0] read_reg(input logic [5:0] a);
    logic [7:0] v;
    v = `DEF_ZERO;
    case (a)
      `ADDR_SETUP1: v = st_r.setup1;
      `ADDR_SETUP2: v = st_r.setup2;
      `ADDR_SETUP3: v = st_r.setup3;
      `ADDR_SETUP4: v = st_r.setup4;
      `ADDR_REVISION: v = REVISION_ID;
      `ADDR_SETUP5: v = st_r.setup5;
      `ADDR_SETUP6: v = st_r.setup6;
      default: v = `DEF_ZERO;
    endcase
    return v;
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev = pin_s;
    if (ser_rise)
    begin
      st_nxt.shift_in = {st_r.shift_in[12:0], pin_s.ser_in};
    end
    if (ser_fall && st_r.rd_busy)
    begin
      if (st_r.rd_cnt != 4'h0)
      begin
        st_nxt.ser_out = st_r.rd_shift[7];
        st_nxt.rd_shift = {st_r.rd_shift[6:0], 1'b0};
        st_nxt.rd_cnt = st_r.rd_cnt - 4'h1;
      end
      else
      begin
        st_nxt.rd_busy = 1'b0;
      end
    end
    if (cyc_rise && st_r.setup4[`BIT_ACYC])
    begin
      if (st_r.acyc == `COL_BLUE)
        st_nxt.acyc = `COL_RED;
      else
        st_nxt.acyc = st_r.acyc + 2'h1;
    end
    if (rd_frame)
    begin
      st_nxt.rd_shift = read_reg({fr_addr[5], 1'b0, fr_addr[3:0]});
      st_nxt.rd_cnt = `RD_BITS;
      st_nxt.rd_busy = 1'b1;
    end
    if (wr_frame)
    begin
      case (fr_addr)
        `ADDR_SETUP1: st_nxt.setup1 = fr_data & `MASK_SETUP1;
        `ADDR_SETUP2: st_nxt.setup2 = fr_data & `MASK_SETUP2;
        `ADDR_SETUP3: st_nxt.setup3 = fr_data;
        `ADDR_SETUP4: st_nxt.setup4 = fr_data;
        `ADDR_SETUP5: st_nxt.setup5 = fr_data & `MASK_SETUP5;
        `ADDR_SETUP6: st_nxt.setup6 = fr_data & `MASK_SETUP6;
        `ADDR_ACYC_RESET: st_nxt.acyc = `COL_RED;
        `ADDR_SOFT_RESET:
        begin
          st_nxt.setup1 = `DEF_SETUP1;
          st_nxt.setup2 = `DEF_SETUP2;
          st_nxt.setup3 = `DEF_SETUP3;
          st_nxt.setup4 = `DEF_ZERO;
          st_nxt.setup5 = `DEF_ZERO;
          st_nxt.setup6 = `DEF_ZERO;
          st_nxt.acyc = `COL_RED;
        end
        default: st_nxt.acyc = st_nxt.acyc;
      endcase
    end

    // sampling pulse, from pin or from detect circuit
    if (det_en)
      st_nxt.sample = dly_pulse;
    else
      st_nxt.sample = strobe_fall;

    // power control, registers untouched by any power state
    if (st_r.setup1[`BIT_SELECTIVE_PD])
      st_nxt.power.block_off = st_r.setup6[`SELDIS_LSB +: 4];
    else
      st_nxt.power.block_off = {4{~st_r.setup1[`BIT_EN]}};
    st_nxt.power.green_off = st_r.setup4[`BIT_LINE] |
      (~st_r.setup1[`BIT_SELECTIVE_PD] & ~st_r.setup1[`BIT_EN]);
    st_nxt.power.blue_off = st_nxt.power.green_off;
    st_nxt.power.single_channel = st_r.setup4[`BIT_LINE] | st_r.setup1[`BIT_SINGLE_CHANNEL];

    // colour multiplexers
    if (st_r.setup4[`BIT_LINE])
    begin
      if (st_r.setup4[`BIT_ACYC])
        st_nxt.mux.og_sel = st_r.acyc;
      else
        st_nxt.mux.og_sel = st_r.setup4[`INTM_LSB +: 2];
      if (st_r.setup4[`BIT_FME])
        st_nxt.mux.in_sel = st_r.setup4[`FM_LSB +: 2];
      else
        st_nxt.mux.in_sel = st_nxt.mux.og_sel;
    end
    else
    begin
      st_nxt.mux.in_sel = st_r.setup3[`CHAN_LSB +: 2];
      st_nxt.mux.og_sel = st_r.setup3[`CHAN_LSB +: 2];
    end

    // shared pin: read-back data while a word is being sent
    st_nxt.pix7 = st_nxt.rd_busy ? st_nxt.ser_out : i_pix_bit7;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_r <= '0;
      st_r.setup1 <= `DEF_SETUP1;
      st_r.setup2 <= `DEF_SETUP2;
      st_r.setup3 <= `DEF_SETUP3;
      st_r.power.block_off <= 4'h0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_pix_out_bit7 = st_r.pix7;
  assign o_pix_out_bit7_oe = ~pin_s.oe_n;
  assign o_sample_take = st_r.sample;
  assign o_power = st_r.power;
  assign o_mux = st_r.mux;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_frame_shift: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ser_rise |=> st_r.shift_in[0] == $past(pin_s.ser_in)
      && st_r.shift_in[13:1] == $past(st_r.shift_in[12:0]))
    else $error("serial bit not shifted in");

  chk_soft_reset: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_frame && fr_addr == `ADDR_SOFT_RESET
      |=> st_r.setup1 == `DEF_SETUP1 && st_r.setup3 == `DEF_SETUP3
        && st_r.setup5 == `DEF_ZERO)
    else $error("soft reset left registers changed");

  chk_readback_load: assert property (@(posedge i_clk) disable iff (!i_rstn)
    rd_frame |=> st_r.rd_busy && st_r.rd_cnt == `RD_BITS)
    else $error("read-back not started");

  chk_readback_bit: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ser_fall && st_r.rd_busy && st_r.rd_cnt != 4'h0 && !rd_frame
      |=> st_r.ser_out == $past(st_r.rd_shift[7]) ##1 o_pix_out_bit7 == $past(st_r.ser_out))
    else $error("read-back bit order wrong");

  chk_input_during_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
    st_r.rd_busy && ser_rise |=> st_r.shift_in[0] == $past(pin_s.ser_in))
    else $error("input frame blocked during read-back");

  chk_pin_sample: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !det_en && strobe_fall |=> o_sample_take)
    else $error("sample missed after strobe fall");

  chk_pin_no_sample: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !det_en && !strobe_fall |=> !o_sample_take)
    else $error("sample without strobe fall");

  chk_strobe_delay: assert property (@(posedge i_clk) disable iff (!i_rstn)
    det_edge && st_r.setup5 == $past(st_r.setup5) && st_r.setup5[`VDEL_LSB +: 3] == 3'h2
      && !latch_rise ##1 !latch_rise ##1 !latch_rise |=> o_sample_take)
    else $error("delayed strobe pulse not on time");

  chk_power_full: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!st_r.setup1[`BIT_SELECTIVE_PD] && !st_r.setup1[`BIT_EN])[*2]
      |-> o_power.block_off == 4'hF && o_power.green_off)
    else $error("full power-down not applied");

  chk_power_sel: assert property (@(posedge i_clk) disable iff (!i_rstn)
    st_r.setup1[`BIT_SELECTIVE_PD] && $stable(st_r.setup6)
      |=> o_power.block_off == $past(st_r.setup6[3:0]))
    else $error("selective block disable wrong");

  chk_line_mode: assert property (@(posedge i_clk) disable iff (!i_rstn)
    st_r.setup4[`BIT_LINE] [*2] |-> o_power.green_off && o_power.blue_off && o_power.single_channel)
    else $error("line mode did not force red single_channel");

  chk_cycle_wrap: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cyc_rise && st_r.setup4[`BIT_ACYC] && st_r.acyc == `COL_BLUE && !wr_frame
      |=> st_r.acyc == `COL_RED)
    else $error("auto-cycle did not wrap to red");

  chk_cycle_reset: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_frame && fr_addr == `ADDR_ACYC_RESET |=> st_r.acyc == `COL_RED)
    else $error("auto-cycle reset ignored");

  chk_force_mux: assert property (@(posedge i_clk) disable iff (!i_rstn)
    st_r.setup4[`BIT_LINE] && st_r.setup4[`BIT_FME] && $stable(st_r.setup4)
      |=> o_mux.in_sel == $past(st_r.setup4[`FM_LSB +: 2]))
    else $error("forced input select not followed");

  chk_detect_now: assert property (@(posedge i_clk) disable iff (!i_rstn)
    det_edge && st_r.setup5[`VDEL_LSB +: 3] == 3'h0 |=> o_sample_take)
    else $error("undelayed detect pulse not sampled");

  chk_power_up: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!st_r.setup1[`BIT_SELECTIVE_PD] && st_r.setup1[`BIT_EN])[*2] |-> o_power.block_off == 4'h0)
    else $error("full power-up not applied");

  chk_regs_kept: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !wr_frame |=> $stable(st_r.setup1) && $stable(st_r.setup4) && $stable(st_r.setup6))
    else $error("register changed without a write");

  chk_mux_internal: assert property (@(posedge i_clk) disable iff (!i_rstn)
    st_r.setup4[`BIT_LINE] && !st_r.setup4[`BIT_FME] && !st_r.setup4[`BIT_ACYC]
      |=> o_mux.in_sel == $past(st_r.setup4[`INTM_LSB +: 2])
        && o_mux.og_sel == $past(st_r.setup4[`INTM_LSB +: 2]))
    else $error("internal colour select not followed");

  chk_mux_autocycle: assert property (@(posedge i_clk) disable iff (!i_rstn)
    st_r.setup4[`BIT_LINE] && st_r.setup4[`BIT_ACYC] |=> o_mux.og_sel == $past(st_r.acyc))
    else $error("offset and gain not auto-cycled");
endmodule // afe_ctrl
`default_nettype wire

// *** dv/afe_host_model.sv ***
`default_nettype none
module afe_host_model (
  input wire logic i_clk,
  input wire logic i_ser_out,
  output logic o_ser_clk,
  output logic o_ser_in,
  output logic o_ser_latch
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_byte;
  event rd_done;
  initial
  begin
    o_ser_clk = 1'b0;
    o_ser_in = 1'b0;
    o_ser_latch = 1'b0;
    rd_byte = 8'h00;
  end
  // ----------------------------------------------------------
  // link half period: four master clocks
  // ----------------------------------------------------------
  task automatic half();
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  // ----------------------------------------------------------
  // frame shift with read-back capture, then latch
  // ----------------------------------------------------------
  task automatic xfer(input logic [13:0] frm, input logic grab);
    for (int i = 13; i >= 0; i--)
    begin
      o_ser_in = frm[i];
      half();
      o_ser_clk = 1'b1;
      half();
      if (i <= 12 && i >= 5)
        rd_byte = {rd_byte[6:0], i_ser_out};
      o_ser_clk = 1'b0;
    end
    half();
    o_ser_in = ~o_ser_in;
    o_ser_latch = 1'b1;
    half();
    o_ser_latch = 1'b0;
    half();
    if (grab)
      ->rd_done;
  endtask
endmodule // afe_host_model
`default_nettype wire

// *** dv/tb_afe_ctrl.sv ***
`default_nettype none
module tb_afe_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import afe_ctrl_pkg::*;
  localparam logic [7:0] REV = 8'hA6; // arbitrary value
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_out_enable_n, i_sample_strobe, i_cycle_pulse_pin, i_pix_bit7;
  logic ser_clk, ser_in, ser_latch, o_pix_out_bit7, o_pix_out_bit7_oe, o_sample_take;
  power_type o_power;
  mux_type o_mux;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h0000531C;
  logic [7:0] sh [16];
  logic [1:0] ac;
  logic pend, pix_chk;
  logic [7:0] pend_val;
  logic [7:0] exp_q [$];
  int take_q [$];

  afe_ctrl #(.REVISION_ID(REV)) u_afe_ctrl (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_ser_clk(ser_clk), .i_ser_in(ser_in), .i_ser_latch(ser_latch),
    .i_out_enable_n(i_out_enable_n), .i_sample_strobe(i_sample_strobe),
    .i_cycle_pulse_pin(i_cycle_pulse_pin), .i_pix_bit7(i_pix_bit7),
    .o_pix_out_bit7(o_pix_out_bit7), .o_pix_out_bit7_oe(o_pix_out_bit7_oe),
    .o_sample_take(o_sample_take), .o_power(o_power), .o_mux(o_mux));
  afe_host_model u_afe_host_model (.i_clk(i_clk), .i_ser_out(o_pix_out_bit7),
    .o_ser_clk(ser_clk), .o_ser_in(ser_in), .o_ser_latch(ser_latch));

  always #25 i_clk = ~i_clk;
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] wmask(input logic [3:0] a);
    case (a)
      4'h1: return 8'h7F;
      4'h2: return 8'hEF;
      4'h3, 4'h6: return 8'hFF;
      4'h8: return 8'h1F;
      4'h9: return 8'h0F;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [10:0] exp_state();
    logic line, off;
    logic [1:0] og;
    line = sh[6][0];
    off = !sh[1][3] && !sh[1][0];
    og = sh[6][1] ? ac : sh[6][5:4];
    return {sh[1][3] ? sh[9][3:0] : {4{off}}, line | off, line | off, sh[1][2] | line,
            line ? (sh[6][2] ? sh[6][7:6] : og) : sh[3][7:6], line ? og : sh[3][7:6]};
  endfunction
  task automatic defaults();
    foreach (sh[i])
      sh[i] = 8'h00;
    sh[1] = 8'h03;
    sh[2] = 8'h20;
    sh[3] = 8'h1F;
    ac = 2'h0;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic frame(input logic [5:0] a, input logic [7:0] d);
    if (pend)
      exp_q.push_back(pend_val);
    u_afe_host_model.xfer({a, d}, pend);
    if (a == 6'h04)
      defaults();
    else if (a == 6'h05)
      ac = 2'h0;
    else if (!a[4])
      sh[a[3:0]] = d & wmask(a[3:0]);
    pend = a[4];
    pend_val = (a[3:0] == 4'h7) ? REV : sh[a[3:0]];
    step(6);
    check({o_power, o_mux}, exp_state());
  endtask
  task automatic cycle();
    i_cycle_pulse_pin = 1'b1;
    step(4);
    i_cycle_pulse_pin = 1'b0;
    if (sh[6][1])
      ac = (ac == 2'h2) ? 2'h0 : ac + 2'h1;
    step(4);
    check({o_power, o_mux}, exp_state());
  endtask
  task automatic strobe(input int w);
    int d;
    d = sh[8][0] ? int'(sh[8][3:1]) : 0;
    i_sample_strobe = 1'b1;
    if (sh[8][0] && sh[8][4])
      take_q.push_back(cyc + 3 + d);
    step(w);
    i_sample_strobe = 1'b0;
    if (!sh[8][0] || !sh[8][4])
      take_q.push_back(cyc + 3 + d);
    step(12);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------
  // monitors
  // ----------------------------------------------------------
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    #1;
    if (o_sample_take === 1'b1)
      check(cyc, take_q.size() ? take_q.pop_front() : -1);
  end
  always @(posedge i_clk)
  begin
    #1;
    if (pix_chk)
      check(o_pix_out_bit7, i_pix_bit7);
    i_pix_bit7 = ^xs();
  end
  initial
    forever
    begin
      @(u_afe_host_model.rd_done);
      check(u_afe_host_model.rd_byte, exp_q.pop_front());
    end
  initial
  begin
    #2000000;
    mismatches++;
    tally_and_finish();
  end
  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial
  begin
    i_out_enable_n = 1'b0;
    i_sample_strobe = 1'b0;
    i_cycle_pulse_pin = 1'b0;
    i_pix_bit7 = 1'b0;
    pend = 1'b0;
    pix_chk = 1'b0;
    defaults();
    repeat (8) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    step(3);
    check({o_power, o_mux}, exp_state());
    check(o_pix_out_bit7_oe, 1'b1);
    for (int a = 1; a < 12; a++)
      if (a != 4)
        frame(6'(a), xs());
    for (int a = 0; a < 16; a++)
      frame(6'(a) | 6'h10, xs());
    frame(6'h04, xs());
    for (int a = 1; a < 4; a++)
      frame(6'(a) | 6'h10, xs());
    $display("test registers done");
    frame(6'h01, 8'h00);
    frame(6'h09, 8'h05);
    frame(6'h01, 8'h08);
    frame(6'h19, xs());
    frame(6'h01, 8'h01);
    $display("test power done");
    frame(6'h03, 8'h80);
    frame(6'h06, 8'h21);
    frame(6'h06, 8'h65);
    frame(6'h06, 8'h67);
    frame(6'h05, xs());
    repeat (4) cycle();
    frame(6'h06, 8'h03);
    repeat (2) cycle();
    frame(6'h05, xs());
    frame(6'h06, 8'h00);
    cycle();
    $display("test colour done");
    frame(6'h08, 8'h00);
    repeat (2) strobe(1);
    for (int d = 0; d < 8; d++)
    begin
      frame(6'h08, 8'h11 | 8'(d << 1));
      strobe(3);
    end
    frame(6'h08, 8'h07);
    repeat (2) strobe(3);
    $display("test strobe done");
    i_out_enable_n = 1'b1;
    step(4);
    check(o_pix_out_bit7_oe, 1'b0);
    pix_chk = 1'b1;
    step(10);
    pix_chk = 1'b0;
    check(take_q.size(), 0);
    check(exp_q.size(), 0);
    $display("test pins done");
    tally_and_finish();
  end
endmodule // tb_afe_ctrl
`default_nettype wire
